// ### hw/dbx_map.svh
// Purpose: opcode patterns, bus codes and exception constants for the debug/branch unit
// Assumes: 16-bit opcode words, 16-bit data bus, 32-bit addresses
// Notes:   definitions only
`ifndef DBX_MAP_SVH
`define DBX_MAP_SVH

// opcode patterns
`define OPC_ENTER_DEBUG  16'h4AFA
`define OPC_BREAKPOINT_INSTR_HI      13'h0909
`define OPC_BRA_HI       8'h60
`define DISP_USE_WORD    8'h00
`define DISP_USE_LONG    8'hFF

// bus cycle codes
`define FC_CPU_SPACE     3'h7
`define FC_SUPER_DATA    3'h5
`define CPU_TYPE_BREAKPOINT_INSTR    4'h0
`define ACK_BYTE_PORT    2'h1
`define ACK_WORD_PORT    2'h2

// exception frame
`define VEC_ILLEGAL      8'h04
`define FRAME_FORMAT0    4'h0
`define PC_STEP          32'h00000002
`define WORD_STEP        32'h00000002

`endif

// ### hw/dbx_pkg.sv
// Purpose: shared types of the debug/branch unit
// Assumes: constants live in dbx_map.svh
// Notes:   no constants here, only types
package dbx_pkg;

    typedef enum logic [1:0] {KIND_NONE, KIND_ENTER_DEBUG, KIND_BREAKPOINT_INSTR, KIND_BRA} instrKind_t;

    typedef struct packed {
        instrKind_t kind;
        logic [2:0] bkptNum;
        logic [7:0] disp8;
    } decoded_t;

    typedef struct packed {
        logic        strobe;
        logic        write;
        logic [2:0]  fc;
        logic [31:0] addr;
        logic [15:0] wdata;
    } busCycle_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_EXT_WORD, ST_EXT_LONG, ST_BREAKPOINT_INSTR, ST_FROZEN, ST_PUSH, ST_VECTOR, ST_HALT
    } state_t;

endpackage

// ### hw/debug_and_branch_instr_exec.sv
// Purpose: execute enter-debug, breakpoint and branch-always instructions
// Assumes: opcode stream from prefetch, word bus with async ack/error pins
// Notes:   other opcodes are handed back through opPass
// Contract
// - enter-debug with debug enabled halts execution and enters background mode
// - freeze is asserted as acknowledgement of background mode
// - leaving background mode resumes at the enter-debug opcode address plus two
// - enter-debug with debug disabled starts illegal-instruction exception
// - exception pushes format word, program counter, status, then loads vector
// - that exception uses the illegal-instruction vector number
// - breakpoint cycle drives number on address 4..2, address 1..0 low; code drives address 0 high on the second byte-port cycle
// - breakpoint cycle is CPU space access of type zero
// - acknowledged breakpoint returns a word that executes next
// - breakpoint cycle fetches a full word, second cycle for byte port
// - bus error on breakpoint cycle gives illegal-instruction exception
// - breakpoint opcode is 4848 plus number in bits 2..0
// - branch target is opcode address plus two plus displacement
// - displacement is a signed byte distance
// - zero 8-bit displacement selects following 16-bit word
// - all-ones 8-bit displacement selects following 32-bit long word
// - branch to next instruction therefore uses 16-bit displacement
// - branch opcode upper byte 60, lower byte is 8-bit displacement
`timescale 1ns/1ps
`include "dbx_map.svh"
module debug_and_branch_instr_exec (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              bgndEnable,
    input  wire logic              debugResume,
    input  wire logic              opValid,
    input  wire logic [15:0]       opWord,
    input  wire logic [31:0]       opAddr,
    output logic                   opReady,
    output logic                   opPass,
    output logic                   pcLoad,
    output logic [31:0]            pcOut,
    output logic                   pipeInsert,
    output logic [15:0]            pipeWord,
    output logic                   freeze,
    input  wire logic [31:0]       sspIn,
    output logic                   sspLoad,
    output logic [31:0]            sspOut,
    input  wire logic [15:0]       srIn,
    input  wire logic [31:0]       vbrIn,
    output dbx_pkg::busCycle_t     bus,
    input  wire logic [15:0]       busRData,
    input  wire logic [1:0]        transferSizeAck,
    input  wire logic              busErrorIn,
    output logic                   ccrWrite
);
    dbx_pkg::state_t    state_q, state_d;
    dbx_pkg::decoded_t  dec;
    dbx_pkg::busCycle_t bus_q, bus_d;
    logic [31:0]        pc_q, pc_d, ssp_q, ssp_d, pcOut_q, pcOut_d;
    logic [15:0]        hi_q, hi_d, pipeWord_q, pipeWord_d;
    logic [7:0]         vec_q, vec_d;
    logic [2:0]         num_q, num_d;
    logic [1:0]         cnt_q, cnt_d;
    logic               freeze_q, freeze_d, pcLoad_q, pcLoad_d, pipeIns_q, pipeIns_d;
    logic               opPass_q, opPass_d, sspLoad_q, sspLoad_d;
    logic [2:0]         pinSync;
    logic [1:0]         ackS;
    logic               berrS, busIdle, ackOk, errOk, take;
    // sign extension of the short displacement
    function automatic logic [31:0] sext8(input logic [7:0] d);
        return {{24{d[7]}}, d};
    endfunction
    // branch target from the opcode address
    function automatic logic [31:0] target(input logic [31:0] a, input logic [31:0] d);
        return a + `PC_STEP + d;
    endfunction
    op_decoder u_dec (
        .opWord (opWord),
        .dec    (dec)
    );
    pin_sync3 #(.W(3)) u_sync (
        .clk    (clk),
        .rstn   (rstn),
        .pinIn  ({transferSizeAck, busErrorIn}),
        .pinOut (pinSync)
    );
    // bus handshake status from synchronised pins
    assign {ackS, berrS} = pinSync;
    assign busIdle = (ackS == 2'h0) && !berrS;
    assign ackOk   = bus_q.strobe && (ackS != 2'h0);
    assign errOk   = bus_q.strobe && berrS && (ackS == 2'h0);
    assign opReady = (state_q == dbx_pkg::ST_IDLE) || (state_q == dbx_pkg::ST_EXT_WORD)
                     || (state_q == dbx_pkg::ST_EXT_LONG);
    assign take    = opValid && opReady;
    // next-state and datapath
    always_comb
    begin
        state_d    = state_q;
        bus_d      = bus_q;
        pc_d       = pc_q;
        ssp_d      = ssp_q;
        pcOut_d    = pcOut_q;
        hi_d       = hi_q;
        pipeWord_d = pipeWord_q;
        vec_d      = vec_q;
        num_d      = num_q;
        cnt_d      = cnt_q;
        freeze_d   = freeze_q;
        {pcLoad_d, pipeIns_d, opPass_d, sspLoad_d} = 4'h0;
        case (state_q)
            dbx_pkg::ST_IDLE:
            begin
                if (take)
                begin
                    pc_d = opAddr;
                    case (dec.kind)
                        dbx_pkg::KIND_ENTER_DEBUG:
                        begin
                            if (bgndEnable)
                            begin
                                state_d  = dbx_pkg::ST_FROZEN;
                                freeze_d = 1'b1;
                            end
                            else
                            begin
                                vec_d   = `VEC_ILLEGAL;
                                ssp_d   = sspIn;
                                cnt_d   = 2'h0;
                                state_d = dbx_pkg::ST_PUSH;
                            end
                        end
                        dbx_pkg::KIND_BREAKPOINT_INSTR:
                        begin
                            num_d   = dec.bkptNum;
                            cnt_d   = 2'h0;
                            state_d = dbx_pkg::ST_BREAKPOINT_INSTR;
                        end
                        dbx_pkg::KIND_BRA:
                        begin
                            if (dec.disp8 == `DISP_USE_WORD)
                                state_d = dbx_pkg::ST_EXT_WORD;
                            else if (dec.disp8 == `DISP_USE_LONG)
                            begin
                                cnt_d   = 2'h0;
                                state_d = dbx_pkg::ST_EXT_LONG;
                            end
                            else
                            begin
                                pcOut_d  = target(opAddr, sext8(dec.disp8));
                                pcLoad_d = 1'b1;
                            end
                        end
                        default:
                            opPass_d = 1'b1;
                    endcase
                end
            end
            dbx_pkg::ST_EXT_WORD:
            begin
                if (take)
                begin
                    pcOut_d  = target(pc_q, {{16{opWord[15]}}, opWord});
                    pcLoad_d = 1'b1;
                    state_d  = dbx_pkg::ST_IDLE;
                end
            end
            dbx_pkg::ST_EXT_LONG:
            begin
                if (take)
                begin
                    if (cnt_q == 2'h0)
                    begin
                        hi_d  = opWord;
                        cnt_d = 2'h1;
                    end
                    else
                    begin
                        pcOut_d  = target(pc_q, {hi_q, opWord});
                        pcLoad_d = 1'b1;
                        state_d  = dbx_pkg::ST_IDLE;
                    end
                end
            end
            dbx_pkg::ST_BREAKPOINT_INSTR:
            begin
                if (!bus_q.strobe && busIdle)
                begin
                    bus_d.strobe = 1'b1;
                    bus_d.write  = 1'b0;
                    bus_d.fc     = `FC_CPU_SPACE;
                    bus_d.addr   = {12'h000, `CPU_TYPE_BREAKPOINT_INSTR, 11'h000, num_q,
                                    1'b0, cnt_q[0]};
                    bus_d.wdata  = 16'h0000;
                end
                else if (ackOk)
                begin
                    bus_d.strobe = 1'b0;
                    if (ackS == `ACK_BYTE_PORT && cnt_q == 2'h0)
                    begin
                        hi_d  = {8'h00, busRData[15:8]};
                        cnt_d = 2'h1;
                    end
                    else
                    begin
                        pipeWord_d = (cnt_q == 2'h0) ? busRData
                                     : {hi_q[7:0], busRData[15:8]};
                        pipeIns_d  = 1'b1;
                        state_d    = dbx_pkg::ST_IDLE;
                    end
                end
                else if (errOk)
                begin
                    bus_d.strobe = 1'b0;
                    vec_d        = `VEC_ILLEGAL;
                    ssp_d        = sspIn;
                    cnt_d        = 2'h0;
                    state_d      = dbx_pkg::ST_PUSH;
                end
            end
            dbx_pkg::ST_FROZEN:
            begin
                if (debugResume)
                begin
                    freeze_d = 1'b0;
                    pcOut_d  = pc_q + `PC_STEP;
                    pcLoad_d = 1'b1;
                    state_d  = dbx_pkg::ST_IDLE;
                end
            end
            dbx_pkg::ST_PUSH:
            begin
                if (!bus_q.strobe && busIdle)
                begin
                    ssp_d        = ssp_q - `WORD_STEP;
                    bus_d.strobe = 1'b1;
                    bus_d.write  = 1'b1;
                    bus_d.fc     = `FC_SUPER_DATA;
                    bus_d.addr   = ssp_q - `WORD_STEP;
                    case (cnt_q)
                        2'h0:    bus_d.wdata = {`FRAME_FORMAT0, 2'h0, vec_q, 2'h0};
                        2'h1:    bus_d.wdata = pc_q[15:0];
                        2'h2:    bus_d.wdata = pc_q[31:16];
                        default: bus_d.wdata = srIn;
                    endcase
                end
                else if (ackOk)
                begin
                    bus_d.strobe = 1'b0;
                    cnt_d        = cnt_q + 2'h1;
                    if (cnt_q == 2'h3)
                    begin
                        sspLoad_d = 1'b1;
                        state_d   = dbx_pkg::ST_VECTOR;
                    end
                end
                else if (errOk)
                begin
                    bus_d.strobe = 1'b0;
                    state_d      = dbx_pkg::ST_HALT;
                end
            end
            dbx_pkg::ST_VECTOR:
            begin
                if (!bus_q.strobe && busIdle)
                begin
                    bus_d.strobe = 1'b1;
                    bus_d.write  = 1'b0;
                    bus_d.fc     = `FC_SUPER_DATA;
                    bus_d.addr   = vbrIn + {22'h0, vec_q, 2'h0} + {30'h0, cnt_q[0], 1'b0};
                    bus_d.wdata  = 16'h0000;
                end
                else if (ackOk)
                begin
                    bus_d.strobe = 1'b0;
                    if (cnt_q == 2'h0)
                    begin
                        hi_d  = busRData;
                        cnt_d = 2'h1;
                    end
                    else
                    begin
                        pcOut_d  = {hi_q, busRData};
                        pcLoad_d = 1'b1;
                        state_d  = dbx_pkg::ST_IDLE;
                    end
                end
                else if (errOk)
                begin
                    bus_d.strobe = 1'b0;
                    state_d      = dbx_pkg::ST_HALT;
                end
            end
            dbx_pkg::ST_HALT:
                state_d = dbx_pkg::ST_HALT;
            default:
                state_d = dbx_pkg::ST_IDLE;
        endcase
    end
    // state registers, all cleared to zero by reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= dbx_pkg::ST_IDLE;
            bus_q   <= '0;
            {pc_q, ssp_q, pcOut_q, hi_q, pipeWord_q, vec_q, num_q, cnt_q} <= '0;
            {freeze_q, pcLoad_q, pipeIns_q, opPass_q, sspLoad_q}          <= '0;
        end
        else
        begin
            state_q <= state_d;
            bus_q   <= bus_d;
            {pc_q, ssp_q, pcOut_q, hi_q, pipeWord_q, vec_q, num_q, cnt_q}
                <= {pc_d, ssp_d, pcOut_d, hi_d, pipeWord_d, vec_d, num_d, cnt_d};
            {freeze_q, pcLoad_q, pipeIns_q, opPass_q, sspLoad_q}
                <= {freeze_d, pcLoad_d, pipeIns_d, opPass_d, sspLoad_d};
        end
    end
    // outputs
    assign bus        = bus_q;
    assign pcOut      = pcOut_q;
    assign pipeWord   = pipeWord_q;
    assign freeze     = freeze_q;
    assign sspOut     = ssp_q;
    assign {pcLoad, pipeInsert, opPass, sspLoad} = {pcLoad_q, pipeIns_q, opPass_q, sspLoad_q};
    assign ccrWrite   = 1'b0;
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_DEBUG_FREEZE: assert property (
        take && state_q == dbx_pkg::ST_IDLE && dec.kind == dbx_pkg::KIND_ENTER_DEBUG && bgndEnable
        |=> freeze && !opReady && !pcLoad) else $error("enter-debug did not freeze");
    AST_FREEZE_HOLD: assert property (freeze && !debugResume |=> freeze)
        else $error("freeze dropped without resume");
    AST_RESUME_PC: assert property (
        freeze && debugResume |=> pcLoad && !freeze && pcOut == $past(pc_q) + 32'h2)
        else $error("resume pc wrong");
    AST_DEBUG_ILLEGAL: assert property (
        take && state_q == dbx_pkg::ST_IDLE && dec.kind == dbx_pkg::KIND_ENTER_DEBUG
        && !bgndEnable |=> state_q == dbx_pkg::ST_PUSH && vec_q == 8'h04 && !freeze)
        else $error("disabled enter-debug not illegal");
    AST_FRAME_FIRST: assert property (
        $rose(bus.strobe) && state_q == dbx_pkg::ST_PUSH && cnt_q == 2'h0
        |-> bus.write && bus.wdata == {4'h0, 2'h0, vec_q, 2'h0} && bus.addr == ssp_q)
        else $error("format word not pushed first");
    AST_BREAKPOINT_INSTR_ADDR: assert property (
        bus.strobe && bus.fc == 3'h7 |-> !bus.write && bus.addr[19:16] == 4'h0
        && bus.addr[4:2] == num_q && bus.addr[1] == 1'b0) else $error("breakpoint address wrong");
    AST_BREAKPOINT_INSTR_WORD: assert property (
        state_q == dbx_pkg::ST_BREAKPOINT_INSTR && ackOk && ackS == 2'h2 && cnt_q == 2'h0
        |=> pipeInsert && pipeWord == $past(busRData) && state_q == dbx_pkg::ST_IDLE)
        else $error("returned word not inserted");
    AST_BREAKPOINT_INSTR_BUS_ERROR_IN: assert property (
        state_q == dbx_pkg::ST_BREAKPOINT_INSTR && errOk |=> state_q == dbx_pkg::ST_PUSH
        && !pipeInsert ##1 !bus.strobe) else $error("bus error not turned into exception");
    AST_BRA_SHORT: assert property (
        take && state_q == dbx_pkg::ST_IDLE && dec.kind == dbx_pkg::KIND_BRA
        && dec.disp8 != 8'h00 && dec.disp8 != 8'hFF
        |=> pcLoad && pcOut == $past(opAddr) + 32'h2 + {{24{$past(opWord[7])}}, $past(opWord[7:0])})
        else $error("short branch target wrong");
    AST_BRA_WORD: assert property (
        take && state_q == dbx_pkg::ST_IDLE && dec.kind == dbx_pkg::KIND_BRA
        && dec.disp8 == 8'h00 |=> state_q == dbx_pkg::ST_EXT_WORD && !pcLoad)
        else $error("zero displacement not extended");
endmodule

// ### hw/op_decoder.sv
// Purpose: classify an opcode word as one of the three handled instructions or as none
// Assumes: word is the first word of an instruction
// Notes:   purely combinational
`timescale 1ns/1ps
`include "dbx_map.svh"
module op_decoder (
    input  wire logic [15:0]      opWord,
    output dbx_pkg::decoded_t     dec
);
    // pattern match on the opcode word
    function automatic dbx_pkg::decoded_t decode(input logic [15:0] w);
        dbx_pkg::decoded_t r;
        r.kind    = dbx_pkg::KIND_NONE;
        r.bkptNum = w[2:0];
        r.disp8   = w[7:0];
        if (w == `OPC_ENTER_DEBUG)
            r.kind = dbx_pkg::KIND_ENTER_DEBUG;
        else if (w[15:3] == `OPC_BREAKPOINT_INSTR_HI)
            r.kind = dbx_pkg::KIND_BREAKPOINT_INSTR;
        else if (w[15:8] == `OPC_BRA_HI)
            r.kind = dbx_pkg::KIND_BRA;
        return r;
    endfunction

    assign dec = decode(opWord);
endmodule

// ### hw/pin_sync3.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins asynchronous to clk
// Notes:   the first stage feeds only the second
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinOut
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] out_d;

    // a bit changes only once stages two and three agree
    always_comb
    begin
        for (int i = 0; i < W; i++)
            out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end

    // stage registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end
        else
        begin
            s1_q  <= pinIn;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign pinOut = out_q;
endmodule

// ### test/breakpoint_instr_emulator.sv
// Purpose: far-side bus agent answering breakpoint, push and vector cycles
// Assumes: mode 0 word ack, 1 byte port, 2 bus error; slow adds wait states
// Notes:   released data shows the inverse of the last value
`timescale 1ns/1ps
module breakpoint_instr_emulator (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire dbx_pkg::busCycle_t bus,
    input  wire logic [1:0]         mode,
    input  wire logic               slow,
    input  wire logic [15:0]        repl,
    input  wire logic [31:0]        vecVal,
    output logic      [1:0]         transferSizeAck,
    output logic                    busErrorIn,
    output logic      [15:0]        busRData
);
    logic [2:0] waitCnt;
    // answer one strobe, release when the strobe drops
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            transferSizeAck <= 2'h0;
            busErrorIn <= 1'b0;
            busRData <= 16'h0;
            waitCnt <= 3'h0;
        end
        else if (!bus.strobe)
        begin
            transferSizeAck <= 2'h0;
            busErrorIn <= 1'b0;
            busRData <= ~busRData;
            waitCnt <= 3'h0;
        end
        else if (transferSizeAck == 2'h0 && !busErrorIn)
        begin
            waitCnt <= waitCnt + 3'h1;
            if (waitCnt >= (slow ? 3'h5 : 3'h1))
            begin
                if (bus.fc != 3'h7)
                    {transferSizeAck, busRData} <= {2'h2, bus.addr[1] ? vecVal[15:0]
                                                          : vecVal[31:16]};
                else if (mode == 2'h2)
                    busErrorIn <= 1'b1;
                else if (mode == 2'h1)
                    {transferSizeAck, busRData} <= {2'h1, bus.addr[0] ? repl[7:0]
                                                          : repl[15:8], 8'h5A};
                else
                    {transferSizeAck, busRData} <= {2'h2, repl};
            end
        end
    end
endmodule

// ### test/debug_and_branch_instr_exec_tb_top.sv
// Purpose: random and corner tests of branch, breakpoint and enter-debug
// Assumes: bench drives at falling edge; emulator answers the bus
// Notes:   expectations are computed here from the opcode fields
`timescale 1ns/1ps
`define CHK(n, e, g) begin nChecks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module debug_and_branch_instr_exec_tb_top;
    logic clk = 0, rstn = 0, bgndEnable = 0, debugResume = 0, opValid = 0, slow = 0;
    logic [15:0] opWord = 0, srIn = 16'h2700, repl = 0, busRData;
    logic [31:0] opAddr = 0, sspIn = 32'h1000, vbrIn = 32'h400, vecVal = 0, pcOut, sspOut;
    logic [1:0] mode = 0, transferSizeAck;
    logic opReady, opPass, pcLoad, pipeInsert, freeze, sspLoad, ccrWrite, busErrorIn, prevS;
    logic [15:0] pipeWord;
    dbx_pkg::busCycle_t bus;
    logic [47:0] wq[$];
    logic [34:0] rq[$];
    int fails = 0, nChecks = 0, seed = 69601, nLd = 0;
    logic [31:0] a, d;
    always #25 clk = ~clk;
    debug_and_branch_instr_exec u_debug_and_branch_instr_exec (.clk(clk), .rstn(rstn),
        .bgndEnable(bgndEnable), .debugResume(debugResume), .opValid(opValid),
        .opWord(opWord), .opAddr(opAddr), .opReady(opReady), .opPass(opPass),
        .pcLoad(pcLoad), .pcOut(pcOut), .pipeInsert(pipeInsert), .pipeWord(pipeWord),
        .freeze(freeze), .sspIn(sspIn), .sspLoad(sspLoad), .sspOut(sspOut), .srIn(srIn),
        .vbrIn(vbrIn), .bus(bus), .busRData(busRData), .transferSizeAck(transferSizeAck),
        .busErrorIn(busErrorIn), .ccrWrite(ccrWrite));
    breakpoint_instr_emulator u_breakpoint_instr_emulator (.clk(clk), .rstn(rstn), .bus(bus), .mode(mode),
        .slow(slow), .repl(repl), .vecVal(vecVal), .transferSizeAck(transferSizeAck),
        .busErrorIn(busErrorIn), .busRData(busRData));
    // log every bus cycle at its strobe rise, sampled mid-cycle where outputs are settled
    always @(negedge clk)
    begin
        prevS <= bus.strobe;
        if (sspLoad)
            nLd++;
        if (bus.strobe && !prevS && bus.write)
            wq.push_back({bus.addr, bus.wdata});
        else if (bus.strobe && !prevS)
            rq.push_back({bus.fc, bus.addr});
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // offer one word and return at the falling edge after it is taken
    task automatic send(input logic [15:0] w);
        @(negedge clk);
        {opValid, opWord, opAddr} = {1'b1, w, a};
        for (int i = 0; !opReady; i++)
        begin
            if (i > 300)
            begin
                fails++;
                report_and_stop();
            end
            @(negedge clk);
        end
        @(posedge clk);
        @(negedge clk);
        opValid = 0;
    endtask
    task automatic waitEv(input bit ins);
        for (int i = 0; !(ins ? pipeInsert : pcLoad); i++)
        begin
            if (i > 300)
            begin
                fails++;
                report_and_stop();
            end
            @(negedge clk);
        end
    endtask
    // frame of four pushes, then the vector lands in the program counter
    task automatic expExc;
        waitEv(0);
        `CHK("vector", vecVal, pcOut)
        `CHK("pushes", 4, wq.size())
        `CHK("fmt", {sspIn - 32'h2, 16'h0010}, wq[0])
        `CHK("pclo", {sspIn - 32'h4, a[15:0]}, wq[1])
        `CHK("pchi", {sspIn - 32'h6, a[31:16]}, wq[2])
        `CHK("sr", {sspIn - 32'h8, srIn}, wq[3])
        `CHK("ssp", sspIn - 32'h8, sspOut)
        `CHK("sspld", 1, nLd)
        nLd = 0;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rstn = 1;
        repeat (4) @(negedge clk);
        for (int k = 0; k < 40; k++)
        begin
            a = $random(seed) & 32'hFFFFFFFE;
            d = $random(seed);
            vecVal = $random(seed) & 32'hFFFFFFFE;
            repl = $random(seed);
            slow = d[9];
            if (d[7:0] == 8'h00 || d[7:0] == 8'hFF)
                d[7:0] = 8'h80;
            send({8'h60, d[7:0]});
            `CHK("bra8", a + 2 + {{24{d[7]}}, d[7:0]}, pcOut)
            send(16'h6000);
            if (k == 0)
                d[31:16] = 16'h0000; // corner: zero 16-bit displacement, target is opcode address plus two
            send(d[31:16]);
            `CHK("bra16", a + 2 + {{16{d[31]}}, d[31:16]}, pcOut)
            send(16'h60FF);
            send(d[31:16]);
            send(~d[15:0]);
            `CHK("bra32", a + 2 + {d[31:16], ~d[15:0]}, pcOut)
            bgndEnable = 1;
            send(16'h4AFA);
            `CHK("freeze", 1'b1, freeze)
            repeat (3) @(negedge clk);
            `CHK("halted", 1'b0, opReady)
            debugResume = 1;
            @(negedge clk);
            debugResume = 0;
            `CHK("thaw", 2'b01, {freeze, pcLoad})
            `CHK("resume", a + 2, pcOut)
            mode = k % 3;
            rq.delete();
            wq.delete();
            send({13'h0909, k[2:0]});
            if (mode == 2'h2)
                expExc();
            else
            begin
                waitEv(1);
                `CHK("repl", repl, pipeWord)
                `CHK("cycles", mode == 2'h1 ? 2 : 1, rq.size())
            end
            `CHK("bkcyc", {3'h7, 27'h0, k[2:0], 2'h0}, rq[0])
            bgndEnable = 0;
            rq.delete();
            wq.delete();
            send(16'h4AFA);
            expExc();
            `CHK("ccr", 1'b0, ccrWrite)
            send({8'h4A, d[7:1], 1'b1});
            `CHK("pass", 2'b10, {opPass, freeze})
            $display("test %0d done", k);
        end
        report_and_stop();
    end
endmodule
